/* File: hw/uart_mp_pkg.sv */
// constants of the serial port control block
package uart_mp_pkg;
	// special-function addresses
	localparam logic [7:0] SERIAL_PORT_CONTROL_ADDR = 8'h98;
	localparam logic [7:0] SERIAL_DATA_BUFFER_ADDR = 8'h99;
	// control register fields
	localparam int FRAME_FORMAT_SELECT_BIT = 7;
	localparam int CONTROL_READS_ONE_BIT = 6;
	localparam int MULTIPROCESSOR_FILTER_ENABLE_BIT = 5;
	localparam int RECEIVE_ENABLE_BIT = 4;
	localparam int TRANSMIT_NINTH_BIT = 3;
	localparam int RECEIVED_NINTH_BIT = 2;
	localparam int TRANSMIT_DONE_FLAG = 1;
	localparam int RECEIVE_DONE_FLAG = 0;
	// reset values
	localparam logic [7:0] SERIAL_PORT_CONTROL_RESET = 8'h40;
	localparam logic [7:0] SERIAL_DATA_BUFFER_RESET = 8'h00;
	// frame shape
	localparam logic [3:0] DATA_BITS = 4'h8;
	localparam int TX_FIFO_DEPTH = 8;
	localparam int TX_FIFO_WIDTH = 8;
	// frame sequencer states, shared by both directions
	typedef enum logic [4:0] {
		FRAME_IDLE = 5'b00001,
		FRAME_START = 5'b00010,
		FRAME_DATA = 5'b00100,
		FRAME_NINTH = 5'b01000,
		FRAME_STOP = 5'b10000
	} frame_state_t;
endpackage

/* File: hw/uart_mp_ctrl.sv */
// serial port control, status, frame engines and transmit queue
//
// How it works
// RULE1 - ninth bit 1 marks an address byte, ninth bit 0 marks data.
// RULE2 - nine-bit mode with filter on: flag only frames whose ninth bit is 1.
// RULE3 - matching slave software clears the filter bit to hear data bytes.
// RULE4 - slaves not addressed keep the filter bit set and ignore data.
// RULE5 - after the message the slave sets the filter bit again.
// RULE6 - control bit 7 picks eight-bit (0) or nine-bit (1) frames.
// RULE7 - control bit 6 always reads 1; writes to it are ignored.
// RULE8 - eight-bit mode with filter on: accept only frames with stop bit 1.
// RULE9 - nine-bit mode with filter off: ninth bit level does not matter.
// RULE10 - control bit 4 turns reception off (0) or on (1).
// RULE11 - control bit 3 is sent as ninth bit in nine-bit mode only.
// RULE12 - control bit 2 catches stop bit (eight-bit) or ninth bit (nine-bit).
// RULE13 - transmit-done flag sets at the start of the stop bit.
// RULE14 - set transmit-done flag requests an interrupt while enabled.
// RULE15 - receive-done sets at stop sampling of accepted frame; interrupts.
// RULE16 - hardware never clears the done flags; software must.
// RULE17 - control register sits at 0x98 on all pages, bit addressable.
// RULE18 - frame loads only while receive-done is clear, else all unchanged.
// RULE19 - nine-bit frame: start, eight data lsb first, ninth, stop bits.
// RULE20 - writing the data buffer starts transmission of a frame; writes queue up here and a full queue drops the write.
// RULE21 - bit rate is timer overflow over two; start reloads receive timer.
// RULE22 - writing 1 to a done flag sets it like a hardware event.
`timescale 1ns/1ps

module tx_byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// fill side
	input wire logic in_valid_i,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic in_ready_o,
	// drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic push;
	logic pop;

	assign in_ready_o = (count_reg != (AW+1)'(DEPTH));
	assign out_valid_o = (count_reg != '0);
	assign out_data_o = mem[rd_ptr_reg];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	always_ff @(posedge sys_clk_i)
	begin
		if (push)
		begin
			mem[wr_ptr_reg] <= in_data_i;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end
		else
		begin
			if (push)
			begin
				wr_ptr_reg <= AW'(wr_ptr_reg + 1'b1);
			end
			if (pop)
			begin
				rd_ptr_reg <= AW'(rd_ptr_reg + 1'b1);
			end
			if (push && !pop)
			begin
				count_reg <= (AW+1)'(count_reg + 1'b1);
			end
			else if (pop && !push)
			begin
				count_reg <= (AW+1)'(count_reg - 1'b1);
			end
		end
	end
endmodule

module uart_mp_ctrl (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// special-function register port
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_bit_wr_i,
	input wire logic [2:0] sfr_bit_sel_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic sfr_rd_i,
	output logic [7:0] sfr_rdata_o,
	output logic tx_space_o,
	// baud timer
	input wire logic tx_timer_ovf_i,
	input wire logic timer_tick_i,
	input wire logic [7:0] timer_reload_i,
	// interrupt
	input wire logic port_irq_enable_i,
	output logic irq_request_o,
	// serial pins
	input wire logic serial_in_pin_i,
	output logic serial_out_pin_o
);
	import uart_mp_pkg::*;

	function automatic logic is_write(input logic [7:0] a);
		is_write = sfr_wr_i && (sfr_addr_i == a);
	endfunction

	// control register fields, kept apart so each has one writer
	logic frame_format_select_reg;
	logic multiprocessor_filter_enable_reg;
	logic receive_enable_bit_reg;
	logic transmit_ninth_bit_reg;
	logic received_ninth_bit_reg;
	logic transmit_done_flag_reg;
	logic receive_done_flag_reg;
	logic [7:0] rx_buffer_reg;
	logic [7:0] control_view;
	logic [7:0] ctl_wdata;
	logic ctl_wr;
	logic rx_accept;
	logic rx_ninth_sample;
	logic tx_done_set;

	// byte writes and single-bit writes both land here
	always_comb
	begin
		ctl_wdata = control_view;
		ctl_wr = 1'b0;
		if (is_write(SERIAL_PORT_CONTROL_ADDR)) // RULE17
		begin
			ctl_wdata = sfr_wdata_i;
			ctl_wr = 1'b1;
		end
		else if (sfr_bit_wr_i && sfr_addr_i == SERIAL_PORT_CONTROL_ADDR)
		begin
			ctl_wdata[sfr_bit_sel_i] = sfr_wdata_i[0]; // RULE17
			ctl_wr = 1'b1;
		end
	end

	always_comb
	begin
		control_view = '0;
		control_view[FRAME_FORMAT_SELECT_BIT] = frame_format_select_reg;
		control_view[CONTROL_READS_ONE_BIT] = 1'b1; // RULE7
		control_view[MULTIPROCESSOR_FILTER_ENABLE_BIT] =
			multiprocessor_filter_enable_reg;
		control_view[RECEIVE_ENABLE_BIT] = receive_enable_bit_reg;
		control_view[TRANSMIT_NINTH_BIT] = transmit_ninth_bit_reg;
		control_view[RECEIVED_NINTH_BIT] = received_ninth_bit_reg;
		control_view[TRANSMIT_DONE_FLAG] = transmit_done_flag_reg;
		control_view[RECEIVE_DONE_FLAG] = receive_done_flag_reg;
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			frame_format_select_reg <=
				SERIAL_PORT_CONTROL_RESET[FRAME_FORMAT_SELECT_BIT];
			multiprocessor_filter_enable_reg <=
				SERIAL_PORT_CONTROL_RESET[MULTIPROCESSOR_FILTER_ENABLE_BIT];
			receive_enable_bit_reg <=
				SERIAL_PORT_CONTROL_RESET[RECEIVE_ENABLE_BIT];
			transmit_ninth_bit_reg <=
				SERIAL_PORT_CONTROL_RESET[TRANSMIT_NINTH_BIT];
		end
		else if (ctl_wr)
		begin
			frame_format_select_reg <= ctl_wdata[FRAME_FORMAT_SELECT_BIT]; // RULE6
			multiprocessor_filter_enable_reg <=
				ctl_wdata[MULTIPROCESSOR_FILTER_ENABLE_BIT];
			receive_enable_bit_reg <= ctl_wdata[RECEIVE_ENABLE_BIT]; // RULE10
			transmit_ninth_bit_reg <= ctl_wdata[TRANSMIT_NINTH_BIT];
		end
	end

	// done flags: a hardware set in the same cycle as a clear wins
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			transmit_done_flag_reg <=
				SERIAL_PORT_CONTROL_RESET[TRANSMIT_DONE_FLAG];
			receive_done_flag_reg <=
				SERIAL_PORT_CONTROL_RESET[RECEIVE_DONE_FLAG];
		end
		else
		begin
			if (tx_done_set) // RULE13
			begin
				transmit_done_flag_reg <= 1'b1;
			end
			else if (ctl_wr) // RULE16 RULE22
			begin
				transmit_done_flag_reg <= ctl_wdata[TRANSMIT_DONE_FLAG];
			end
			if (rx_accept) // RULE15
			begin
				receive_done_flag_reg <= 1'b1;
			end
			else if (ctl_wr) // RULE16 RULE22
			begin
				receive_done_flag_reg <= ctl_wdata[RECEIVE_DONE_FLAG];
			end
		end
	end

	// receive buffer moves only on an accepted frame; received ninth bit also takes control writes
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			received_ninth_bit_reg <=
				SERIAL_PORT_CONTROL_RESET[RECEIVED_NINTH_BIT];
		end
		else if (rx_accept)
		begin
			received_ninth_bit_reg <= rx_ninth_sample; // RULE12
		end
		else if (ctl_wr)
		begin
			received_ninth_bit_reg <= ctl_wdata[RECEIVED_NINTH_BIT];
		end
	end

	// registered read data and interrupt request
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sfr_rdata_o <= 8'h00;
			irq_request_o <= 1'b0;
		end
		else
		begin
			if (sfr_rd_i && sfr_addr_i == SERIAL_PORT_CONTROL_ADDR)
			begin
				sfr_rdata_o <= control_view;
			end
			else if (sfr_rd_i && sfr_addr_i == SERIAL_DATA_BUFFER_ADDR)
			begin
				sfr_rdata_o <= rx_buffer_reg;
			end
			else if (sfr_rd_i)
			begin
				sfr_rdata_o <= 8'h00;
			end
			irq_request_o <= port_irq_enable_i &&
				(transmit_done_flag_reg || receive_done_flag_reg); // RULE14 RULE15
		end
	end

	// transmit: writes queue up; a full queue drops the write
	logic fifo_out_valid;
	logic fifo_pop;
	logic fifo_in_ready;
	logic [7:0] fifo_out_data;
	frame_state_t tx_state_reg;
	logic tx_half_reg;
	logic [8:0] tx_shift_reg;
	logic [3:0] tx_count_reg;
	logic tx_bit_en;

	tx_byte_fifo #(
		.WIDTH(TX_FIFO_WIDTH),
		.DEPTH(TX_FIFO_DEPTH)
	) tx_queue (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.in_valid_i(is_write(SERIAL_DATA_BUFFER_ADDR)), // RULE20
		.in_data_i(sfr_wdata_i),
		.in_ready_o(fifo_in_ready),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(fifo_pop),
		.out_data_o(fifo_out_data)
	);

	assign fifo_pop = (tx_state_reg == FRAME_IDLE) && fifo_out_valid;
	assign tx_bit_en = tx_timer_ovf_i && tx_half_reg; // RULE21
	assign tx_done_set = tx_bit_en && (tx_count_reg == 4'h0) &&
		((tx_state_reg == FRAME_DATA && !frame_format_select_reg) ||
		tx_state_reg == FRAME_NINTH); // RULE13

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			tx_space_o <= 1'b1;
		end
		else
		begin
			tx_space_o <= fifo_in_ready;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			tx_half_reg <= 1'b0;
		end
		else if (tx_timer_ovf_i)
		begin
			tx_half_reg <= !tx_half_reg;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			tx_state_reg <= FRAME_IDLE;
			tx_shift_reg <= 9'h1ff;
			tx_count_reg <= 4'h0;
			serial_out_pin_o <= 1'b1;
		end
		else
		begin
			case (tx_state_reg)
			FRAME_IDLE:
			begin
				if (fifo_pop)
				begin
					// ninth bit is taken when the frame begins
					tx_shift_reg <= {transmit_ninth_bit_reg, fifo_out_data}; // RULE11
					tx_state_reg <= FRAME_START;
				end
			end
			FRAME_START:
			begin
				if (tx_bit_en)
				begin
					serial_out_pin_o <= 1'b0;
					tx_count_reg <= DATA_BITS;
					tx_state_reg <= FRAME_DATA;
				end
			end
			FRAME_DATA:
			begin
				if (tx_bit_en && tx_count_reg != 4'h0)
				begin
					serial_out_pin_o <= tx_shift_reg[0]; // RULE19
					tx_shift_reg <= {1'b1, tx_shift_reg[8:1]};
					tx_count_reg <= 4'(tx_count_reg - 1'b1);
				end
				else if (tx_bit_en && frame_format_select_reg)
				begin
					serial_out_pin_o <= tx_shift_reg[0]; // RULE11 RULE1
					tx_state_reg <= FRAME_NINTH;
				end
				else if (tx_bit_en)
				begin
					serial_out_pin_o <= 1'b1;
					tx_state_reg <= FRAME_STOP;
				end
			end
			FRAME_NINTH:
			begin
				if (tx_bit_en)
				begin
					serial_out_pin_o <= 1'b1; // RULE19
					tx_state_reg <= FRAME_STOP;
				end
			end
			FRAME_STOP:
			begin
				if (tx_bit_en)
				begin
					tx_state_reg <= FRAME_IDLE;
				end
			end
			default:
			begin
				tx_state_reg <= FRAME_IDLE;
			end
			endcase
		end
	end

	// receive line synchroniser
	logic rx_meta_reg;
	logic rx_sync_reg;
	logic rx_prev_reg;
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rx_meta_reg <= 1'b1;
			rx_sync_reg <= 1'b1;
			rx_prev_reg <= 1'b1;
		end
		else
		begin
			rx_meta_reg <= serial_in_pin_i;
			rx_sync_reg <= rx_meta_reg;
			rx_prev_reg <= rx_sync_reg;
		end
	end

	// receive timer copy: reloaded on a start edge so sampling is centred
	frame_state_t rx_state_reg;
	logic [7:0] rx_timer_reg;
	logic rx_half_reg;
	logic rx_start_edge;
	logic rx_sample;
	logic [7:0] rx_shift_reg;
	logic [3:0] rx_count_reg;
	logic rx_ninth_reg;

	assign rx_start_edge = (rx_state_reg == FRAME_IDLE) &&
		receive_enable_bit_reg && rx_prev_reg && !rx_sync_reg; // RULE10
	assign rx_sample = timer_tick_i && (rx_timer_reg == 8'hff) && rx_half_reg;
	assign rx_ninth_sample = frame_format_select_reg ? rx_ninth_reg :
		rx_sync_reg; // RULE12
	// overrun: the held byte stays, the new one is dropped
	assign rx_accept = rx_sample && (rx_state_reg == FRAME_STOP) &&
		!receive_done_flag_reg && // RULE18
		(!multiprocessor_filter_enable_reg || rx_ninth_sample); // RULE2 RULE8 RULE9

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rx_timer_reg <= 8'h00;
			rx_half_reg <= 1'b0;
		end
		else if (rx_start_edge)
		begin
			rx_timer_reg <= timer_reload_i; // RULE21
			rx_half_reg <= 1'b1;
		end
		else if (timer_tick_i && rx_timer_reg == 8'hff)
		begin
			rx_timer_reg <= timer_reload_i;
			rx_half_reg <= !rx_half_reg; // RULE21
		end
		else if (timer_tick_i)
		begin
			rx_timer_reg <= 8'(rx_timer_reg + 1'b1);
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rx_buffer_reg <= SERIAL_DATA_BUFFER_RESET;
		end
		else if (rx_accept)
		begin
			rx_buffer_reg <= rx_shift_reg; // RULE18
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rx_state_reg <= FRAME_IDLE;
			rx_shift_reg <= 8'h00;
			rx_count_reg <= 4'h0;
			rx_ninth_reg <= 1'b0;
		end
		else
		begin
			case (rx_state_reg)
			FRAME_IDLE:
			begin
				if (rx_start_edge)
				begin
					rx_state_reg <= FRAME_START;
				end
			end
			FRAME_START:
			begin
				// a glitch shorter than half a bit is not a start
				if (rx_sample && rx_sync_reg)
				begin
					rx_state_reg <= FRAME_IDLE;
				end
				else if (rx_sample)
				begin
					rx_count_reg <= DATA_BITS;
					rx_state_reg <= FRAME_DATA;
				end
			end
			FRAME_DATA:
			begin
				if (rx_sample)
				begin
					rx_shift_reg <= {rx_sync_reg, rx_shift_reg[7:1]}; // RULE19
					rx_count_reg <= 4'(rx_count_reg - 1'b1);
					if (rx_count_reg == 4'h1)
					begin
						rx_state_reg <= frame_format_select_reg ?
							FRAME_NINTH : FRAME_STOP;
					end
				end
			end
			FRAME_NINTH:
			begin
				if (rx_sample)
				begin
					rx_ninth_reg <= rx_sync_reg; // RULE1
					rx_state_reg <= FRAME_STOP;
				end
			end
			FRAME_STOP:
			begin
				if (rx_sample)
				begin
					rx_state_reg <= FRAME_IDLE;
				end
			end
			default:
			begin
				rx_state_reg <= FRAME_IDLE;
			end
			endcase
		end
	end
endmodule

/* File: verif/uart_mp_ctrl_props.sv */
// port assertions for the serial port control block
`timescale 1ns/1ps
module uart_mp_ctrl_props (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// register port
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_bit_wr_i,
	input wire logic [2:0] sfr_bit_sel_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic sfr_rd_i,
	input wire logic [7:0] sfr_rdata_o,
	input wire logic tx_space_o,
	// timer, interrupt, pin
	input wire logic tx_timer_ovf_i,
	input wire logic port_irq_enable_i,
	input wire logic irq_request_o,
	input wire logic serial_out_pin_o
);
	import uart_mp_pkg::*;
	logic wr_ctl;
	logic bw_ctl;
	logic rd_ctl;
	logic rd_clean;
	logic set_tx;
	logic wbit;
	logic [3:0] sw_bits;
	assign wr_ctl = sfr_wr_i && sfr_addr_i == SERIAL_PORT_CONTROL_ADDR;
	assign rd_ctl = sfr_rd_i && sfr_addr_i == SERIAL_PORT_CONTROL_ADDR;
	assign rd_clean = rd_ctl && !sfr_wr_i && !sfr_bit_wr_i;
	assign bw_ctl = sfr_bit_wr_i && !sfr_wr_i
		&& sfr_addr_i == SERIAL_PORT_CONTROL_ADDR;
	assign set_tx = bw_ctl && sfr_bit_sel_i == 3'h1 && sfr_wdata_i[0];
	assign wbit = sfr_wdata_i[0];
	assign sw_bits = {sfr_wdata_i[7], sfr_wdata_i[5:3]};
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	chk_bit6_reads_one:
	assert property (rd_ctl |=> sfr_rdata_o[6])
		else $error("control bit 6 read as 0");
	chk_unmapped_reads_zero:
	assert property (sfr_rd_i && sfr_addr_i != SERIAL_PORT_CONTROL_ADDR
		&& sfr_addr_i != SERIAL_DATA_BUFFER_ADDR |=> sfr_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	chk_rdata_holds:
	assert property (!sfr_rd_i |=> $stable(sfr_rdata_o))
		else $error("read data moved without a read");
	chk_irq_needs_enable:
	assert property (!port_irq_enable_i |=> !irq_request_o)
		else $error("request while port interrupt disabled");
	chk_irq_on_set:
	assert property (set_tx ##1 port_irq_enable_i |=> irq_request_o)
		else $error("software flag set raised no request");
	chk_pin_on_enable:
	assert property ($changed(serial_out_pin_o) |-> $past(tx_timer_ovf_i))
		else $error("serial out moved off a bit enable");
	chk_ctl_write_back:
	assert property (wr_ctl ##1 !sfr_wr_i && !sfr_bit_wr_i ##1 rd_clean
		|=> {sfr_rdata_o[7], sfr_rdata_o[5:3]} == $past(sw_bits, 3))
		else $error("control bits read back wrong");
	// flags and bit 2 excluded: hardware may move them meanwhile
	chk_bit_write_back:
	assert property (bw_ctl && sfr_bit_sel_i > 3'h2 && sfr_bit_sel_i != 3'h6
		##1 !sfr_wr_i && !sfr_bit_wr_i ##1 rd_clean
		|=> sfr_rdata_o[$past(sfr_bit_sel_i, 3)] == $past(wbit, 3))
		else $error("bit write read back wrong");
	cover property ($rose(irq_request_o));
	cover property ($fell(serial_out_pin_o));
	cover property ($fell(tx_space_o));
endmodule
bind uart_mp_ctrl uart_mp_ctrl_props uart_mp_ctrl_props_inst (
	.sys_clk_i, .rst_n_i, .sfr_addr_i, .sfr_wr_i, .sfr_bit_wr_i,
	.sfr_bit_sel_i, .sfr_wdata_i, .sfr_rd_i, .sfr_rdata_o, .tx_space_o,
	.tx_timer_ovf_i, .port_irq_enable_i, .irq_request_o, .serial_out_pin_o
);

/* File: verif/remote_node.sv */
// far processor on the serial link: sends frames and decodes ours
`timescale 1ns/1ps
module remote_node #(
	parameter int SEND_BIT = 32,
	parameter int LISTEN_BIT = 8
) (
	// clock
	input wire logic sys_clk_i,
	// link
	input wire logic line_i,
	input wire logic nine_bit_i,
	output logic line_o
);
	logic [7:0] last_byte;
	logic last_ninth;
	int frames = 0;
	initial line_o = 1'b1;
	// two idle bits follow so a low stop never looks like a start edge
	task automatic send(input logic [7:0] b, input logic b9);
		logic [10:0] f;
		f = {1'b1, b9, b, 1'b0};
		for (int n = 0; n < 13; n++)
		begin
			@(posedge sys_clk_i);
			line_o <= (n < 11) ? f[n] : 1'b1;
			repeat (SEND_BIT - 1) @(posedge sys_clk_i);
		end
	endtask
	// samples mid-bit, away from the edges where the pin moves
	always
	begin
		@(negedge line_i);
		repeat (LISTEN_BIT / 2) @(posedge sys_clk_i);
		for (int i = 0; i < 9; i++)
		begin
			repeat (LISTEN_BIT) @(posedge sys_clk_i);
			if (i < 8)
				last_byte[i] = line_i;
			else
				last_ninth = line_i;
		end
		if (nine_bit_i)
			repeat (LISTEN_BIT) @(posedge sys_clk_i);
		frames++;
	end
endmodule

/* File: verif/uart_mp_ctrl_tb.sv */
// self-checking bench for the serial port control block
`timescale 1ns/1ps
module uart_mp_ctrl_tb;
	import uart_mp_pkg::*;
	typedef struct packed {
		logic [7:0] ctl;
		logic [7:0] data;
		logic b9;
		logic [7:0] exp;
		logic keep;
	} rx_case_t;
	logic sys_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [7:0] sfr_addr_i = 8'h00;
	logic sfr_wr_i = 1'b0;
	logic sfr_bit_wr_i = 1'b0;
	logic [2:0] sfr_bit_sel_i = 3'h0;
	logic [7:0] sfr_wdata_i = 8'h00;
	logic sfr_rd_i = 1'b0;
	logic [7:0] sfr_rdata_o;
	logic tx_space_o;
	logic tx_timer_ovf_i = 1'b0;
	logic timer_tick_i = 1'b1;
	logic [7:0] timer_reload_i = 8'hf0;
	logic port_irq_enable_i = 1'b0;
	logic irq_request_o;
	logic serial_in_pin_i;
	logic serial_out_pin_o;
	logic nine_mode = 1'b1;
	logic [1:0] ovf_cnt = 2'h0;
	logic [7:0] d;
	logic [7:0] rx_exp = 8'h00;
	int fails = 0;
	int checks = 0;
	// data hidden, address, data heard, filter re-armed, disabled, stop checks, full
	rx_case_t cases [9] = '{
		'{8'hb0, 8'h11, 1'b0, 8'hf0, 1'b0},
		'{8'hb0, 8'h22, 1'b1, 8'hf5, 1'b0},
		'{8'h90, 8'h44, 1'b0, 8'hd1, 1'b0},
		'{8'hb0, 8'h33, 1'b0, 8'hf0, 1'b0},
		'{8'ha0, 8'h33, 1'b1, 8'he0, 1'b0},
		'{8'h30, 8'h55, 1'b0, 8'h70, 1'b0},
		'{8'h10, 8'h66, 1'b0, 8'h51, 1'b0},
		'{8'h30, 8'h77, 1'b1, 8'h75, 1'b0},
		'{8'h15, 8'h88, 1'b0, 8'h55, 1'b1}
	};
	always #25 sys_clk_i = ~sys_clk_i;
	// overflow every 4 clocks gives an 8-clock bit on the wire
	always @(posedge sys_clk_i)
	begin
		ovf_cnt <= ovf_cnt + 2'h1;
		tx_timer_ovf_i <= (ovf_cnt == 2'h3);
	end
	uart_mp_ctrl uart_mp_ctrl_inst (.sys_clk_i, .rst_n_i, .sfr_addr_i,
		.sfr_wr_i, .sfr_bit_wr_i, .sfr_bit_sel_i, .sfr_wdata_i, .sfr_rd_i,
		.sfr_rdata_o, .tx_space_o, .tx_timer_ovf_i, .timer_tick_i,
		.timer_reload_i, .port_irq_enable_i, .irq_request_o,
		.serial_in_pin_i, .serial_out_pin_o);
	remote_node remote_node_inst (.sys_clk_i, .line_i(serial_out_pin_o),
		.nine_bit_i(nine_mode), .line_o(serial_in_pin_i));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge sys_clk_i);
		sfr_addr_i <= a;
		sfr_wdata_i <= v;
		sfr_wr_i <= 1'b1;
		@(posedge sys_clk_i);
		sfr_wr_i <= 1'b0;
	endtask
	task automatic bwr(input logic [2:0] s, input logic v);
		@(posedge sys_clk_i);
		sfr_addr_i <= SERIAL_PORT_CONTROL_ADDR;
		sfr_bit_sel_i <= s;
		sfr_wdata_i <= {7'h00, v};
		sfr_bit_wr_i <= 1'b1;
		@(posedge sys_clk_i);
		sfr_bit_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk_i);
		sfr_addr_i <= a;
		sfr_rd_i <= 1'b1;
		@(posedge sys_clk_i);
		sfr_rd_i <= 1'b0;
		@(negedge sys_clk_i);
		d = sfr_rdata_o;
	endtask
	task automatic wait_frames(input int n);
		for (int k = 0; k < 3000 && remote_node_inst.frames < n; k++)
			@(posedge sys_clk_i);
		@(negedge sys_clk_i);
	endtask
	task automatic tally_and_finish;
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (16) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		rd(SERIAL_PORT_CONTROL_ADDR);
		chk(d, SERIAL_PORT_CONTROL_RESET);
		rd(SERIAL_DATA_BUFFER_ADDR);
		chk(d, SERIAL_DATA_BUFFER_RESET);
		rd(8'h9a);
		chk(d, 8'h00);
		wr(SERIAL_PORT_CONTROL_ADDR, 8'h38);
		rd(SERIAL_PORT_CONTROL_ADDR);
		chk(d, 8'h78);
		$display("test registers done");
		@(posedge sys_clk_i);
		port_irq_enable_i <= 1'b1;
		wr(SERIAL_PORT_CONTROL_ADDR, 8'h00);
		bwr(3'h1, 1'b1);
		rd(SERIAL_PORT_CONTROL_ADDR);
		chk(d, 8'h42);
		chk({7'h00, irq_request_o}, 8'h01);
		@(posedge sys_clk_i);
		port_irq_enable_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
		chk({7'h00, irq_request_o}, 8'h00);
		bwr(3'h1, 1'b0);
		bwr(3'h0, 1'b1);
		bwr(3'h7, 1'b1);
		rd(SERIAL_PORT_CONTROL_ADDR);
		chk(d, 8'hc1);
		$display("test interrupt done");
		wr(SERIAL_PORT_CONTROL_ADDR, 8'h88);
		wr(SERIAL_DATA_BUFFER_ADDR, 8'ha5);
		wait_frames(1);
		chk(remote_node_inst.last_byte, 8'ha5);
		chk({7'h00, remote_node_inst.last_ninth}, 8'h01);
		rd(SERIAL_PORT_CONTROL_ADDR);
		chk(d, 8'hca);
		// ninth bit clear in an eight-bit frame: stop must still be high
		nine_mode <= 1'b0;
		wr(SERIAL_PORT_CONTROL_ADDR, 8'h00);
		wr(SERIAL_DATA_BUFFER_ADDR, 8'h3c);
		wait_frames(2);
		chk(remote_node_inst.last_byte, 8'h3c);
		chk({7'h00, remote_node_inst.last_ninth}, 8'h01);
		repeat (100) @(posedge sys_clk_i);
		rd(SERIAL_PORT_CONTROL_ADDR);
		chk(d, 8'h42);
		$display("test transmit done");
		for (int i = 0; i < 10; i++)
			wr(SERIAL_DATA_BUFFER_ADDR, 8'h10 + 8'(i));
		@(negedge sys_clk_i);
		chk({7'h00, tx_space_o}, 8'h00);
		wait_frames(11);
		repeat (200) @(posedge sys_clk_i);
		chk(8'(remote_node_inst.frames), 8'h0b);
		chk(remote_node_inst.last_byte, 8'h18);
		chk({7'h00, tx_space_o}, 8'h01);
		$display("test queue done");
		for (int i = 0; i < 9; i++)
		begin
			wr(SERIAL_PORT_CONTROL_ADDR, cases[i].ctl);
			remote_node_inst.send(cases[i].data, cases[i].b9);
			if (cases[i].exp[0] && !cases[i].keep)
				rx_exp = cases[i].data;
			rd(SERIAL_PORT_CONTROL_ADDR);
			chk(d, cases[i].exp);
			rd(SERIAL_DATA_BUFFER_ADDR);
			chk(d, rx_exp);
		end
		$display("test receive done");
		tally_and_finish;
	end
	// the whole run needs under 10000 clocks
	initial
	begin
		repeat (40000) @(posedge sys_clk_i);
		fails++;
		tally_and_finish;
	end
endmodule
